// ---- hdl/bhp_pin_mux.sv ----
// Notes on behaviour
// - Receive data taken LSB first on RXD
// - Ring pin: general input or serial clock
// - Gen B timer mode pulses its pin
// - Gen B clock mode drives clock, and DTR too
// - DSR pin: input, gen A, or output
// - RTS is CPU output, used in auto-transmit
// - RTS is input during reset, output after
// - CTS gates transmit in auto mode
// - DCD pin: input, system clock, or output
// - All units except bus raise block interrupts
// - Per-FIFO threshold raises FIFO interrupt
// - 8-bit data, 3-bit address plus bank
// - Four banks, one reachable at once
// - Writing bank field switches bank
// - Banks: compat, work, config, modem config
// - Bank 0 selected after power-up
// - Other registers default to compatible values
// - Bus unit owns accesses and interrupt request
// - RTS low at reset selects crystal
// - Reset restores bank and pin functions
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "bhp_consts.svh"

module bhp_pin_mux
  import bhp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  address,
  input  wire logic        chipselect,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  input  wire logic        rxdIn,
  input  wire logic        riIn,
  input  wire logic        ctsIn,
  input  wire logic        dsrIn,
  output var  logic        dsrOut,
  output var  logic        dsrOe,
  input  wire logic        dcdIn,
  output var  logic        dcdOut,
  output var  logic        dcdOe,
  input  wire logic        rtsIn,
  output var  logic        rtsOut,
  output var  logic        rtsOe,
  output var  logic        dtrOut,
  output var  logic        out2Out,
  output var  logic        out2Oe,
  input  wire logic        genAOut,
  input  wire logic        genBOut,
  input  wire logic [3:0]  unitIrq,
  input  wire logic [2:0]  subIrq,
  input  wire logic [2:0]  rxLevel,
  input  wire logic [2:0]  txLevel,
  output var  logic        rxData,
  output var  logic        receiveClock,
  output var  logic        transmitClock,
  output var  logic        txGate,
  output var  logic        crystalSelect,
  output var  logic        sysClockOut,
  output var  logic        intReq
);

  bhp_state_s_t r;
  bhp_state_s_t next_r;
  logic [5:0]   pinsIn;
  logic [4:0]   slot;
  logic [7:0]   pinCtl;
  logic [7:0]   modemCmd;
  logic [7:0]   genMode;
  logic [7:0]   fifoThr;
  logic [5:0]   blockIrq;
  logic [5:0]   gatedIrq;
  logic [7:0]   pinStat;
  logic         busReq;

  // Raw pin vector and named views of owned registers
  assign pinsIn   = {rtsIn, dcdIn, ctsIn, dsrIn, riIn, rxdIn};
  assign slot     = {r.bank, address};
  assign pinCtl   = r.regs[`BHP_SLOT_PIN_CTL];
  assign modemCmd = r.regs[`BHP_SLOT_MODEM_CMD];
  assign genMode  = r.regs[`BHP_SLOT_GEN_MODE];
  assign fifoThr  = r.regs[`BHP_SLOT_FIFO_THR];
  assign busReq   = chipselect && (read || write);

  // Block interrupt vector; second-level requests fold into their blocks
  // FIFO threshold compare
  assign blockIrq[0] = (rxLevel != 3'h0) &&
                       (rxLevel >= fifoThr[`BHP_FT_RX_MSB:`BHP_FT_RX_LSB]);
  assign blockIrq[1] = txLevel <= fifoThr[`BHP_FT_TX_MSB:`BHP_FT_TX_LSB];
  assign blockIrq[2] = unitIrq[0] || subIrq[0];
  assign blockIrq[3] = unitIrq[1] || subIrq[2];
  assign blockIrq[4] = unitIrq[2];
  assign blockIrq[5] = unitIrq[3] || subIrq[1];
  assign gatedIrq    = blockIrq & r.regs[`BHP_SLOT_ENABLE][5:0];

  // Live pin status, active-low pins shown as asserted-high
  // ring readable by CPU
  assign pinStat = {3'h0, r.crystal, ~r.flt[`BHP_PIN_DCD],
                    ~r.flt[`BHP_PIN_RI], ~r.flt[`BHP_PIN_DSR],
                    ~r.flt[`BHP_PIN_CTS]};

  // Next-state logic for the whole block
  always_comb begin
    next_r = r;
    // Three-stage synchroniser; a change counts when stages two and three agree
    next_r.sync1 = pinsIn;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    next_r.flt   = (r.sync2 & ~(r.sync2 ^ r.sync3)) |
                   (r.flt & (r.sync2 ^ r.sync3));
    next_r.sysClkDiv = ~r.sysClkDiv;

    // Bus handshake: one wait cycle, write lands at the acknowledge edge
    // bus unit accesses
    unique case (r.state)
      BHP_IDLE: begin
        next_r.waitReq = 1'b1;
        if (busReq) begin
          next_r.state   = BHP_ACK;
          next_r.waitReq = 1'b0;
          if (address == `BHP_ADDR_BANK) begin
            next_r.rdData = {1'b0, r.bank, 4'h0, ~r.intReq};
          end else if (slot == `BHP_SLOT_PIN_STAT) begin
            next_r.rdData = pinStat;
          end else begin
            next_r.rdData = r.regs[slot];
          end
        end
      end
      BHP_ACK: begin
        next_r.state   = BHP_IDLE;
        next_r.waitReq = 1'b1;
        if (write && byteenable[0]) begin
          if (address == `BHP_ADDR_BANK) begin
            next_r.bank = writedata[`BHP_BANK_MSB:`BHP_BANK_LSB];
          end else if (slot != `BHP_SLOT_PIN_STAT) begin
            next_r.regs[slot] = writedata[7:0];
          end
        end
      end
    endcase

    // Serial receive data passes to the receive machine, LSB first
    // receive data path
    next_r.rxData = r.flt[`BHP_PIN_RXD];

    // Serial clock selection from the ring pin or the generators
    // ring as serial clock
    next_r.receive_clock = pinCtl[`BHP_PC_RX_SCLK] ? r.flt[`BHP_PIN_RI] : genAOut;
    next_r.transmit_clock = pinCtl[`BHP_PC_TX_SCLK] ? r.flt[`BHP_PIN_RI] : genBOut;

    // DTR pin: modem output or generator B
    // timer pulse on pin
    next_r.dtrOut = pinCtl[`BHP_PC_DTR_GEN] ? genBOut
                                            : ~modemCmd[`BHP_MC_DTR];

    // DSR pin function
    // DSR pin select
    unique case (pinCtl[`BHP_PC_DSR_MSB:`BHP_PC_DSR_LSB])
      `BHP_FN_TIMING: begin
        next_r.dsrOut = genAOut;
        next_r.dsrOe  = 1'b1;
      end
      `BHP_FN_GENOUT: begin
        next_r.dsrOut = ~modemCmd[`BHP_MC_GENERAL_OUTPUT_ZERO];
        next_r.dsrOe  = 1'b1;
      end
      default: begin
        next_r.dsrOut = 1'b1;
        next_r.dsrOe  = 1'b0;
      end
    endcase

    // DCD pin function
    // DCD pin select
    unique case (pinCtl[`BHP_PC_DCD_MSB:`BHP_PC_DCD_LSB])
      `BHP_FN_TIMING: begin
        next_r.dcdOut = r.sysClkDiv;
        next_r.dcdOe  = 1'b1;
      end
      `BHP_FN_GENOUT: begin
        next_r.dcdOut = ~modemCmd[`BHP_MC_GENERAL_OUTPUT_ONE];
        next_r.dcdOe  = 1'b1;
      end
      default: begin
        next_r.dcdOut = 1'b1;
        next_r.dcdOe  = 1'b0;
      end
    endcase

    // RTS output from the CPU bit
    // RTS under CPU control
    next_r.rtsOut = ~modemCmd[`BHP_MC_RTS];
    next_r.rtsOe  = 1'b1;

    // General output two exists only with an external clock
    next_r.out2Out = ~modemCmd[`BHP_MC_GENERAL_OUTPUT_TWO];
    next_r.out2Oe  = ~r.crystal;

    // Transmit gate: in auto mode needs CTS and RTS both asserted
    // CTS gates transmitter
    next_r.txGate = pinCtl[`BHP_PC_AUTO_TX] ?
                    (~r.flt[`BHP_PIN_CTS] && modemCmd[`BHP_MC_RTS]) : 1'b1;

    // Single interrupt request to the system
    // interrupt request out
    next_r.intReq = |gatedIrq;

    // Reset: defaults, bank 0, modem pin functions, RTS as input
    if (rst) begin
      next_r.bank    = `BHP_BANK_COMPAT;
      next_r.state   = BHP_IDLE;
      next_r.waitReq = 1'b1;
      next_r.rdData  = 8'h00;
      next_r.regs    = '0;
      next_r.regs[`BHP_SLOT_PIN_CTL]   = `BHP_RST_PIN_CTL;
      next_r.regs[`BHP_SLOT_MODEM_CMD] = `BHP_RST_MODEM_CMD;
      next_r.regs[`BHP_SLOT_FIFO_THR]  = `BHP_RST_FIFO_THR;
      next_r.regs[`BHP_SLOT_ENABLE]    = `BHP_RST_ENABLE;
      next_r.regs[`BHP_SLOT_GEN_MODE]  = `BHP_RST_GEN_MODE;
      next_r.rtsOe   = 1'b0;
      next_r.rtsOut  = 1'b1;
      next_r.crystal = ~r.flt[`BHP_PIN_RTS];
      next_r.dsrOe   = 1'b0;
      next_r.dsrOut  = 1'b1;
      next_r.dcdOe   = 1'b0;
      next_r.dcdOut  = 1'b1;
      next_r.dtrOut  = 1'b1;
      next_r.out2Oe  = 1'b0;
      next_r.out2Out = 1'b1;
      next_r.txGate  = 1'b1;
      next_r.intReq  = 1'b0;
      next_r.rxData  = 1'b1;
      next_r.receive_clock   = 1'b0;
      next_r.transmit_clock   = 1'b0;
      next_r.sysClkDiv = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    r <= next_r;
  end

  // Outputs straight from the state register
  assign readdata      = {24'h00_0000, r.rdData};
  assign waitrequest   = r.waitReq;
  assign dsrOut        = r.dsrOut;
  assign dsrOe         = r.dsrOe;
  assign dcdOut        = r.dcdOut;
  assign dcdOe         = r.dcdOe;
  assign rtsOut        = r.rtsOut;
  assign rtsOe         = r.rtsOe;
  assign dtrOut        = r.dtrOut;
  assign out2Out       = r.out2Out;
  assign out2Oe        = r.out2Oe;
  assign rxData        = r.rxData;
  assign receiveClock  = r.receive_clock;
  assign transmitClock = r.transmit_clock;
  assign txGate        = r.txGate;
  assign crystalSelect = r.crystal;
  assign sysClockOut   = r.sysClkDiv;
  assign intReq        = r.intReq;

  // Checks on the behaviour above
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence reqSeen;
    r.state == BHP_IDLE && busReq;
  endsequence

  sequence ackPulse;
    !waitrequest ##1 waitrequest;
  endsequence

  bus_ack_a: assert property (reqSeen |=> ackPulse)
    else $error("bus request not acknowledged in one cycle");

  bank_write_a: assert property (
    (r.state == BHP_ACK && write && byteenable[0] &&
     address == `BHP_ADDR_BANK) |=>
    r.bank == $past(writedata[`BHP_BANK_MSB:`BHP_BANK_LSB]))
    else $error("bank pointer write lost");

  reset_bank_a: assert property (
    $fell(rst) |-> r.bank == `BHP_BANK_COMPAT &&
                   pinCtl == `BHP_RST_PIN_CTL)
    else $error("reset did not restore bank and pins");

  rts_strap_a: assert property ($fell(rst) |-> !rtsOe ##1 rtsOe)
    else $error("RTS direction wrong around reset");

  crystal_pick_a: assert property (
    $fell(rst) |-> crystalSelect == !$past(r.flt[`BHP_PIN_RTS]))
    else $error("clock strap not captured");

  gen_b_timer_a: assert property (
    (pinCtl[`BHP_PC_DTR_GEN] && !genMode[`BHP_GM_GEN_B]) |=>
    dtrOut == $past(genBOut))
    else $error("timer pulse not on DTR pin");

  gen_b_clock_a: assert property (
    (pinCtl[`BHP_PC_DTR_GEN] && genMode[`BHP_GM_GEN_B]) |=>
    dtrOut == $past(genBOut))
    else $error("generator clock not on DTR pin");

  dsr_input_a: assert property (
    pinCtl[`BHP_PC_DSR_MSB:`BHP_PC_DSR_LSB] == `BHP_FN_MODEM |=> !dsrOe)
    else $error("DSR driven while input");

  dcd_clock_a: assert property (
    pinCtl[`BHP_PC_DCD_MSB:`BHP_PC_DCD_LSB] == `BHP_FN_TIMING |=>
    dcdOe && dcdOut == $past(sysClockOut))
    else $error("DCD pin not carrying system clock");

  cts_gate_a: assert property (
    (pinCtl[`BHP_PC_AUTO_TX] && r.flt[`BHP_PIN_CTS]) |=> !txGate)
    else $error("transmit not held by CTS");

  fifo_thresh_a: assert property (
    (blockIrq[0] && r.regs[`BHP_SLOT_ENABLE][0]) |=> intReq)
    else $error("FIFO threshold interrupt missing");

  rx_path_a: assert property (
    (r.sync2[0] == r.sync3[0]) |=> ##1 rxData == $past(r.sync2[0], 2))
    else $error("receive data path broken");

  ring_clock_a: assert property (
    pinCtl[`BHP_PC_RX_SCLK] |=> receiveClock == $past(r.flt[`BHP_PIN_RI]))
    else $error("ring pin not used as receive clock");

  rts_cpu_a: assert property (
    rtsOe |=> rtsOe && rtsOut == !$past(modemCmd[`BHP_MC_RTS]))
    else $error("RTS pin not following the CPU bit");

  pin_default_a: assert property (
    $fell(rst) |-> !dsrOe && !dcdOe && dtrOut && out2Out)
    else $error("multifunction pins not at modem defaults");

  modem_irq_a: assert property (
    ((unitIrq[1] || subIrq[2]) && r.regs[`BHP_SLOT_ENABLE][3]) |=> intReq)
    else $error("modem block interrupt missing");

  irq_quiet_a: assert property (
    (r.regs[`BHP_SLOT_ENABLE][5:0] == 6'h00) |=> !intReq)
    else $error("interrupt request with all blocks masked");

  bank_read_a: assert property (
    (r.state == BHP_IDLE && busReq && read && address == `BHP_ADDR_BANK) |=>
    readdata[`BHP_BANK_MSB:`BHP_BANK_LSB] == $past(r.bank))
    else $error("bank pointer read not current");

endmodule : bhp_pin_mux

`default_nettype wire

// ---- hdl/bhp_consts.svh ----
`ifndef BHP_CONSTS_SVH
`define BHP_CONSTS_SVH

// Pin vector positions of the synchronised inputs
`define BHP_PIN_RXD        3'd0
`define BHP_PIN_RI         3'd1
`define BHP_PIN_DSR        3'd2
`define BHP_PIN_CTS        3'd3
`define BHP_PIN_DCD        3'd4
`define BHP_PIN_RTS        3'd5

// Register slots: slot = {bank, word address}
`define BHP_ADDR_BANK      3'd2
`define BHP_SLOT_ENABLE    5'd1
`define BHP_SLOT_MODEM_CMD 5'd4
`define BHP_SLOT_PIN_STAT  5'd6
`define BHP_SLOT_FIFO_THR  5'd19
`define BHP_SLOT_PIN_CTL   5'd24
`define BHP_SLOT_GEN_MODE  5'd25

// Bank pointer field in the bank register
`define BHP_BANK_MSB       6
`define BHP_BANK_LSB       5
`define BHP_BANK_COMPAT    2'h0

// Pin control register fields
`define BHP_PC_DSR_MSB     1
`define BHP_PC_DSR_LSB     0
`define BHP_PC_DCD_MSB     3
`define BHP_PC_DCD_LSB     2
`define BHP_PC_DTR_GEN     4
`define BHP_PC_AUTO_TX     5
`define BHP_PC_RX_SCLK     6
`define BHP_PC_TX_SCLK     7

// Multifunction pin codes (two-bit fields)
`define BHP_FN_MODEM       2'h0
`define BHP_FN_TIMING      2'h1
`define BHP_FN_GENOUT      2'h2

// Modem command bits (set means asserted, pin goes low)
`define BHP_MC_DTR         0
`define BHP_MC_RTS         1
`define BHP_MC_GENERAL_OUTPUT_ZERO        2
`define BHP_MC_GENERAL_OUTPUT_ONE        3
`define BHP_MC_GENERAL_OUTPUT_TWO        4

// Generator mode bits: set means clock generator, clear means timer
`define BHP_GM_GEN_A       0
`define BHP_GM_GEN_B       1

// FIFO threshold fields
`define BHP_FT_RX_MSB      2
`define BHP_FT_RX_LSB      0
`define BHP_FT_TX_MSB      6
`define BHP_FT_TX_LSB      4

// Reset values
`define BHP_RST_PIN_CTL    8'h00
`define BHP_RST_MODEM_CMD  8'h00
`define BHP_RST_FIFO_THR   8'h01
`define BHP_RST_ENABLE     8'h00
`define BHP_RST_GEN_MODE   8'h00

`endif

// ---- hdl/bhp_pkg.sv ----
`default_nettype none

package bhp_pkg;

  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    BHP_IDLE = 2'b01,
    BHP_ACK  = 2'b10
  } bhp_state_t;

  // Whole state of the pin mux
  typedef struct packed {
    logic [5:0]       sync1;
    logic [5:0]       sync2;
    logic [5:0]       sync3;
    logic [5:0]       flt;
    bhp_state_t       state;
    logic             waitReq;
    logic [7:0]       rdData;
    logic [31:0][7:0] regs;
    logic [1:0]       bank;
    logic             crystal;
    logic             sysClkDiv;
    logic             rxData;
    logic             receive_clock;
    logic             transmit_clock;
    logic             dtrOut;
    logic             dsrOut;
    logic             dsrOe;
    logic             dcdOut;
    logic             dcdOe;
    logic             rtsOut;
    logic             rtsOe;
    logic             out2Out;
    logic             out2Oe;
    logic             txGate;
    logic             intReq;
  } bhp_state_s_t;

endpackage : bhp_pkg

`default_nettype wire

// ---- tb/bhp_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module bhp_host_model (
  input  wire logic        sys_clk,
  output var  logic [2:0]  address,
  output var  logic        chipselect,
  output var  logic        read,
  output var  logic        write,
  output var  logic [31:0] writedata,
  output var  logic [3:0]  byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  // Bus idle at time zero
  initial begin
    address = 3'h0;
    chipselect = 1'b0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
  end

  // One transfer, held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [2:0] a,
                      input logic [7:0] d);
    @(posedge sys_clk);
    chipselect <= 1'b1;
    address    <= a;
    writedata  <= {24'h00_0000, d};
    byteenable <= 4'h1;
    write      <= wr;
    read       <= !wr;
    // Held until the rising edge that samples waitrequest low
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    // Released address and data lines show the inverse of the last value
    chipselect <= 1'b0;
    write      <= 1'b0;
    read       <= 1'b0;
    address    <= ~a;
    writedata  <= ~writedata;
  endtask : xfer
endmodule : bhp_host_model

`default_nettype wire

// ---- tb/tb_banked_host_port_pin_mux.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_banked_host_port_pin_mux
  import bhp_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  address;
  logic        chipselect, read, write;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic        waitrequest, dsrOut, dsrOe, dcdOut, dcdOe, rtsOut, rtsOe;
  logic        dtrOut, out2Out, out2Oe, rxData, receiveClock;
  logic        transmitClock, txGate, crystalSelect, sysClockOut, intReq;
  logic        rxdIn = 1'b1, riIn = 1'b1, ctsIn = 1'b1, rtsStrap = 1'b0;
  logic        genAOut = 1'b0, genBOut = 1'b0, v;
  logic [2:0]  rxLevel = 3'h0, txLevel = 3'h0, subIrq = 3'h0;
  logic [3:0]  unitIrq = 4'h0;
  // Block served by each bit of {subIrq, unitIrq}, bit 0 first
  logic [20:0] blkMap = {3'd3, 3'd5, 3'd2, 3'd5, 3'd4, 3'd3, 3'd2};
  logic [7:0]  r;
  logic [7:0]  expQ[$];
  int          failures = 0, check_count = 0, cyc = 0;
  // Pin wires resolved from the drive enables
  wire         rtsIn = rtsOe ? rtsOut : rtsStrap;
  wire         dsrIn = dsrOe ? dsrOut : 1'b1;
  wire         dcdIn = dcdOe ? dcdOut : 1'b1;

  // Clock
  always #5 sys_clk = !sys_clk;

  bhp_host_model host (.sys_clk(sys_clk), .address(address),
    .chipselect(chipselect), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest));

  bhp_pin_mux DUT (.sys_clk(sys_clk), .rst(rst), .address(address),
    .chipselect(chipselect), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .rxdIn(rxdIn),
    .riIn(riIn), .ctsIn(ctsIn), .dsrIn(dsrIn), .dsrOut(dsrOut),
    .dsrOe(dsrOe), .dcdIn(dcdIn), .dcdOut(dcdOut), .dcdOe(dcdOe),
    .rtsIn(rtsIn), .rtsOut(rtsOut), .rtsOe(rtsOe), .dtrOut(dtrOut),
    .out2Out(out2Out), .out2Oe(out2Oe), .genAOut(genAOut),
    .genBOut(genBOut), .unitIrq(unitIrq), .subIrq(subIrq),
    .rxLevel(rxLevel), .txLevel(txLevel), .rxData(rxData),
    .receiveClock(receiveClock), .transmitClock(transmitClock),
    .txGate(txGate), .crystalSelect(crystalSelect),
    .sysClockOut(sysClockOut), .intReq(intReq));

  task automatic chk(input string n, input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask : rd

  // Wait n edges, then look at settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  // Read data against the oldest note, taken at the acknowledge edge
  always @(posedge sys_clk) begin
    if (waitrequest === 1'b0 && read === 1'b1 && expQ.size() > 0) begin
      chk("readdata", readdata[7:0], expQ.pop_front());
    end
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    r = $urandom(32'h1d4ed5b4);
    settle(10);
    chk("rtsOe in reset", rtsOe, 1'b0);
    settle(9);
    @(posedge sys_clk);
    rst <= 1'b0;
    settle(2);
    chk("crystal", {crystalSelect, out2Oe}, 2'b10);
    chk("rts dtr", {rtsOe, rtsOut, dtrOut}, 3'b111);
    chk("modem pins", {dsrOe, dcdOe}, 2'b00);
    rd(3'h2, 8'h01);
    $display("test reset done");
    for (int b = 0; b < 4; b++) begin
      wr(3'h2, {1'b0, b[1:0], 5'h00});
      rd(3'h2, {1'b0, b[1:0], 5'h01});
    end
    r = 8'($urandom);
    wr(3'h2, 8'h20);
    wr(3'h1, r);
    wr(3'h2, 8'h00);
    rd(3'h1, 8'h00);
    wr(3'h2, 8'h20);
    rd(3'h1, r);
    $display("test banks done");
    wr(3'h2, 8'h60);
    wr(3'h0, 8'h15);
    for (int i = 0; i < 4; i++) begin
      v = 1'($urandom);
      wr(3'h1, {6'h00, i[1], 1'b0});
      @(posedge sys_clk);
      genAOut <= v;
      genBOut <= !v;
      settle(3);
      chk("dsr gen A", {dsrOe, dsrOut}, {1'b1, v});
      chk("dtr gen B", dtrOut, !v);
      chk("gen clocks", {receiveClock, transmitClock}, {v, !v});
    end
    v = dcdOut;
    settle(1);
    chk("dcd clock", {dcdOe, dcdOut}, {1'b1, !v});
    chk("sys clock", sysClockOut, v);
    wr(3'h0, 8'h20);
    wr(3'h2, 8'h00);
    wr(3'h4, 8'h02);
    @(posedge sys_clk);
    ctsIn <= 1'b0;
    riIn <= 1'b0;
    settle(8);
    chk("rtsOut", {rtsOe, rtsOut}, 2'b10);
    chk("txGate on", txGate, 1'b1);
    rd(3'h6, 8'h15);
    @(posedge sys_clk);
    ctsIn <= 1'b1;
    settle(8);
    chk("txGate off", txGate, 1'b0);
    wr(3'h2, 8'h60);
    wr(3'h0, 8'hca);
    wr(3'h2, 8'h00);
    wr(3'h4, 8'h0c);
    settle(2);
    chk("general outs", {dsrOe, dsrOut, dcdOe, dcdOut}, 4'b1010);
    chk("ring clocks low", {receiveClock, transmitClock}, 2'b00);
    @(posedge sys_clk);
    riIn <= 1'b1;
    settle(6);
    chk("ring clocks high", {receiveClock, transmitClock}, 2'b11);
    $display("test pins done");
    wr(3'h1, 8'h01);
    @(posedge sys_clk);
    rxLevel <= 3'h2;
    settle(6);
    chk("intReq", intReq, 1'b1);
    rd(3'h2, 8'h00);
    wr(3'h1, 8'h00);
    settle(6);
    chk("intReq masked", intReq, 1'b0);
    @(posedge sys_clk);
    rxLevel <= 3'h0;
    txLevel <= 3'h7;
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      {subIrq, unitIrq} <= 7'(1 << i);
      wr(3'h1, 8'(1 << blkMap[3*i +: 3]));
      settle(2);
      chk("own block", intReq, 1'b1);
      wr(3'h1, 8'(8'h3f ^ (1 << blkMap[3*i +: 3])));
      settle(2);
      chk("other blocks", intReq, 1'b0);
    end
    wr(3'h1, 8'h02);
    @(posedge sys_clk);
    {subIrq, unitIrq} <= 7'h00;
    txLevel <= 3'h0;
    settle(2);
    chk("tx fifo irq", intReq, 1'b1);
    r = 8'($urandom);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      rxdIn <= r[i];
      settle(6);
      chk("rxData", rxData, r[i]);
    end
    $display("test irq rx done");
    wr(3'h2, 8'h60);
    @(posedge sys_clk);
    rst <= 1'b1;
    rtsStrap <= 1'b1;
    settle(8);
    chk("pins in reset", {rtsOe, dsrOe, dcdOe}, 3'b000);
    @(posedge sys_clk);
    rst <= 1'b0;
    settle(2);
    chk("ext clock", {crystalSelect, out2Oe}, 2'b01);
    rd(3'h2, 8'h01);
    wr(3'h4, 8'h10);
    settle(2);
    chk("general_output_two", {out2Oe, out2Out}, 2'b10);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : tb_banked_host_port_pin_mux

`default_nettype wire
